// >>> scc_bench.sv
// Self-checking bench for the system clock controller
`timescale 1ns/100ps
module scc_bench;
    import scc_pkg::*;
    logic MCLK, SRST, CKEN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic RC_OSC, EXT_OSC, IRQ, SYS_TICK, AUDIO_MCK, rerr, ext_run, gap_on;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rdata, v;
    scc_ticks_t DOM_TICK;
    int err_count, comparisons, seed, gap, min_gap, a;
    int cnt[7];

    scc_top scc_top_i (.MCLK, .SRST, .CKEN, .PSEL, .PENABLE, .PWRITE,
        .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RC_OSC, .EXT_OSC,
        .IRQ, .SYS_TICK, .DOM_TICK, .AUDIO_MCK);
    scc_osc scc_osc_i (.clk(MCLK), .ext_run, .rc_osc(RC_OSC),
        .ext_osc(EXT_OSC));

    initial
    begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end

    // Shortest spacing of system ticks while a plain source runs
    // Frozen cycles hold SYS_TICK at its last value, so only enabled edges count
    always @(posedge MCLK)
    begin
        if (CKEN === 1'b1)
        begin
            gap <= gap + 1;
            if (SYS_TICK === 1'b1)
            begin
                if (gap_on && gap < min_gap)
                    min_gap <= gap;
                gap <= 0;
            end
        end
    end

    task automatic finish_test(input logic tout);
        if (tout)
        begin
            err_count++;
            $display("ERROR wait expected answer seen timeout");
        end
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_n(input string nm, input int e, input int g);
        comparisons++;
        if (g < e - 2 || g > e + 2)
        begin
            err_count++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_n

    // Holds the request until ready, then one idle edge
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d);
        int n;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge MCLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 16);
        rdata = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
        if (n >= 16)
            finish_test(1'b1);
    endtask : apb

    task automatic rd(input logic [7:0] ad);
        apb(1'b0, ad, 32'h00000000);
    endtask : rd

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask : wr

    task automatic poll(input logic [7:0] ad, input logic [31:0] m,
        input logic [31:0] e);
        int n;
        n = 0;
        do
        begin
            rd(ad);
            n++;
        end
        while ((rdata & m) !== e && n < 400);
        if (n >= 400)
            finish_test(1'b1);
    endtask : poll

    task automatic count(input int n);
        logic last;
        cnt = '{default: 0};
        last = AUDIO_MCK;
        repeat (n)
        begin
            @(posedge MCLK);
            // Unknown ticks count as none, so they cannot slip through
            cnt[0] += (SYS_TICK === 1'b1);
            for (int k = 0; k < 5; k++)
                cnt[k + 1] += (DOM_TICK[k] === 1'b1);
            cnt[6] += (AUDIO_MCK !== last);
            last = AUDIO_MCK;
        end
    endtask : count

    function automatic int tcode(input logic [2:0] p, input logic s);
        if (s)
            return (p <= 3'h2) ? 0 : p - 2;
        return (p == 3'h0) ? 0 : p - 1;
    endfunction : tcode

    task automatic reset_regs;
        rd(ADDR_CTRL);
        chk("ctrl", CTRL_RST, rdata);
        rd(ADDR_PLLCFG);
        chk("pllcfg", PLLCFG_RST, rdata);
        rd(ADDR_PRESC);
        chk("presc", PRESC_RST, rdata);
        rd(ADDR_IRQ_MASK);
        chk("mask", 32'h00000000, rdata);
        rd(ADDR_STATUS);
        chk("active", {30'h0, SRC_RC}, {30'h0, rdata[1:0]});
    endtask : reset_regs

    initial
    begin
        seed = 75;
        err_count = 0;
        comparisons = 0;
        SRST = 1'b1;
        CKEN = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h00000000;
        ext_run = 1'b1;
        gap_on = 1'b0;
        gap = 0;
        min_gap = 1000;
        repeat (16) @(posedge MCLK);
        SRST <= 1'b0;
        @(posedge MCLK);
        reset_regs();
        rd(8'h18);
        chk("slverr", 32'h1, {31'h0, rerr});
        chk("unmapped", 32'h0, rdata);
        v = $random(seed);
        wr(ADDR_IRQ_MASK, v);
        rd(ADDR_IRQ_MASK);
        chk("mask rw", v & 32'h7, rdata);
        wr(ADDR_PLLCFG, v);
        rd(ADDR_PLLCFG);
        chk("pllcfg rw", v & PLLCFG_WMASK, rdata);
        wr(ADDR_PLLCFG, PLLCFG_RST);
        // Dividers from the RC source, one fixed corner among random codes
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 1) ? 32'h00000320 : $random(seed) & 32'h00000771;
            wr(ADDR_CTRL, {26'h0, i[0], 5'h0});
            wr(ADDR_PRESC, v);
            count(4096);
            a = 512 >> v[2:0];
            chk_n("sys", 512, cnt[0]);
            chk_n("ahb", a, cnt[1]);
            chk_n("apb1", a >> v[6:4], cnt[2]);
            chk_n("apb2", a >> v[10:8], cnt[3]);
            chk_n("tim1", a >> tcode(v[6:4], i[0]), cnt[4]);
            chk_n("tim2", a >> tcode(v[10:8], i[0]), cnt[5]);
        end
        gap_on = 1'b1;
        wr(ADDR_CTRL, 32'h00000001);
        poll(ADDR_STATUS, 32'h3, 32'h1);
        CKEN <= 1'b0;
        repeat (10) @(posedge MCLK);
        CKEN <= 1'b1;
        count(600);
        chk_n("ext ticks", 100, cnt[0]);
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_CTRL, 32'h00000009);
        ext_run <= 1'b0;
        poll(ADDR_STATUS, 32'h7, 32'h0);
        rd(ADDR_IRQ_STAT);
        chk("ext fail", 32'h1, rdata & 32'h1);
        chk("irq masked", 32'h0, {31'h0, IRQ});
        wr(ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge MCLK);
        chk("irq on", 32'h1, {31'h0, IRQ});
        wr(ADDR_IRQ_STAT, 32'h1);
        repeat (2) @(posedge MCLK);
        chk("irq clear", 32'h0, {31'h0, IRQ});
        chk("no runt", 32'h1, {31'h0, min_gap >= 5});
        gap_on = 1'b0;
        ext_run <= 1'b1;
        wr(ADDR_CTRL, 32'h00000002);
        poll(ADDR_STATUS, 32'h8, 32'h8);
        rd(ADDR_IRQ_STAT);
        chk("lock event", 32'h4, rdata & 32'h4);
        wr(ADDR_CTRL, 32'h00000006);
        poll(ADDR_STATUS, 32'h3, 32'h2);
        count(800);
        chk_n("pll ticks", 400, cnt[0]);
        // Second reset while the PLL drives the system clock
        SRST <= 1'b1;
        repeat (3) @(posedge MCLK);
        SRST <= 1'b0;
        @(posedge MCLK);
        reset_regs();
        wr(ADDR_CTRL, 32'h0000000B);
        poll(ADDR_STATUS, 32'h8, 32'h8);
        wr(ADDR_CTRL, 32'h0000000F);
        poll(ADDR_STATUS, 32'h3, 32'h2);
        ext_run <= 1'b0;
        poll(ADDR_STATUS, 32'h3, 32'h0);
        rd(ADDR_IRQ_STAT);
        chk("ref fail", 32'h2, rdata & 32'h2);
        ext_run <= 1'b1;
        wr(ADDR_CTRL, 32'h00000010);
        poll(ADDR_STATUS, 32'h10, 32'h10);
        count(1000);
        chk_n("audio mck", 100, cnt[6]);
        finish_test(1'b0);
    end
endmodule : scc_bench

// >>> scc_chk.sv
// Port checks for the system clock controller
`timescale 1ns/100ps
module scc_chk
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CKEN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ,
    input wire logic SYS_TICK,
    input wire scc_pkg::scc_ticks_t DOM_TICK,
    input wire logic AUDIO_MCK
);
    import scc_pkg::*;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SRST);

    property p_rst_quiet;
        $fell(SRST) |-> !IRQ && !SYS_TICK && !AUDIO_MCK && !PREADY
            && DOM_TICK == '0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs busy after reset");
    property p_one_wait;
        (PSEL && !PENABLE && CKEN) ##1 (PSEL && PENABLE && CKEN) |=> PREADY;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("ready late");
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held");
    property p_ready_cause;
        PREADY |-> PSEL && PENABLE && $past(PENABLE);
    endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without access");
    property p_err_ready;
        PSLVERR |-> PREADY;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    property p_unmapped;
        PREADY && PADDR > ADDR_IRQ_MASK |-> PSLVERR && (PWRITE || PRDATA == '0);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access accepted");
    property p_mapped;
        PREADY && PADDR <= ADDR_IRQ_MASK && PADDR[1:0] == 2'h0 |-> !PSLVERR;
    endproperty
    a_mapped: assert property (p_mapped)
        else $error("mapped access refused");
    property p_irq_fall;
        $fell(IRQ) |-> $past(PREADY && PWRITE) || $past(PREADY && PWRITE, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without write");
    property p_freeze;
        !CKEN |=> $stable(IRQ) && $stable(AUDIO_MCK) && $stable(PRDATA);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while frozen");
endmodule : scc_chk

bind scc_top scc_chk scc_chk_i (.MCLK, .SRST, .CKEN, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .IRQ, .SYS_TICK,
    .DOM_TICK, .AUDIO_MCK);

// >>> scc_div.sv
// Power-of-two tick prescaler for one clock domain
`timescale 1ns/100ps

module scc_div
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick_in,
    input wire logic [scc_pkg::DIV_W-1:0] div_code,
    output logic tick_out
);
    import scc_pkg::*;

    localparam int CNT_W = 2 ** DIV_W - 1;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mask;

    assign mask = CNT_W'((1 << div_code) - 1);

    // Output only ever pulses on an input tick, so no runt can appear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end
        else if (ce)
        begin
            tick_out <= tick_in && ((cnt_q & mask) == mask);
            if (tick_in)
                cnt_q <= cnt_q + CNT_W'(1);
        end
    end

endmodule : scc_div

// >>> scc_mon.sv
// Activity monitor that flags a clock source gone silent
`timescale 1ns/100ps

module scc_mon
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic en,
    input wire logic tick,
    output logic ok,
    output logic fail
);
    import scc_pkg::*;

    logic [MON_W-1:0] cnt_q;

    // Reads ok while disabled so the source stays selectable
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            ok <= 1'b1;
            fail <= 1'b0;
        end
        else if (ce)
        begin
            fail <= 1'b0;
            if (!en)
            begin
                cnt_q <= '0;
                ok <= 1'b1;
            end
            else if (tick)
            begin
                cnt_q <= '0;
                ok <= 1'b1;
            end
            else if (cnt_q == MON_W'(FAIL_CYC - 1))
            begin
                fail <= ok;
                ok <= 1'b0;
            end
            else
                cnt_q <= cnt_q + MON_W'(1);
        end
    end

endmodule : scc_mon

// >>> scc_osc.sv
// Oscillator pins: internal RC source and a stoppable external one
`timescale 1ns/100ps
module scc_osc
#(
    parameter int RC_HALF = 4,
    parameter int EXT_HALF = 3
)
(
    input wire logic clk,
    input wire logic ext_run,
    output logic rc_osc,
    output logic ext_osc
);
    // Scaled periods: pins must stay slower than a quarter of MCLK
    int rc_cnt = 0;
    int ext_cnt = 0;
    initial rc_osc = 1'b0;
    initial ext_osc = 1'b0;
    always @(posedge clk)
    begin
        rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
        if (rc_cnt == RC_HALF - 1)
            rc_osc <= ~rc_osc;
        ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
        // A failed crystal goes silent, not stuck at its last edge
        if (!ext_run)
            ext_osc <= 1'b0;
        else if (ext_cnt == EXT_HALF - 1)
            ext_osc <= ~ext_osc;
    end
endmodule : scc_osc

// >>> scc_pkg.sv
// Constants and types shared by the system clock controller
package scc_pkg;

    // Timing
    localparam int CLK_MHZ = 50;
    localparam int FAIL_NS = 1000;
    localparam int FAIL_CYC = (FAIL_NS * CLK_MHZ) / 1000;
    localparam int MON_W = 6;
    localparam int LOCK_REF_TICKS = 64;
    localparam int LOCK_W = 7;
    localparam int CREDIT_W = 12;
    localparam logic [CREDIT_W-1:0] CREDIT_MAX = 12'hEFF;

    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PLLCFG = 8'h04;
    localparam logic [7:0] ADDR_PRESC = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    localparam logic [31:0] CTRL_WMASK = 32'h0000003F;
    localparam logic [31:0] PLLCFG_WMASK = 32'h00FFFFFF;
    localparam logic [31:0] PRESC_WMASK = 32'h00000777;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [31:0] PLLCFG_RST = 32'h00040404;
    localparam logic [31:0] PRESC_RST = 32'h00000000;

    // Interrupt status and mask bits
    localparam int IRQ_EXT_FAIL = 0;
    localparam int IRQ_PLL_FAIL = 1;
    localparam int IRQ_PLL_LOCK = 2;
    localparam int IRQ_W = 3;

    // Divider channels
    localparam int CH_AHB = 0;
    localparam int CH_APB1 = 1;
    localparam int CH_APB2 = 2;
    localparam int CH_TIM1 = 3;
    localparam int CH_TIM2 = 4;
    localparam int N_CH = 5;
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] TIM_FULL_CODE = 3'h2;

    localparam int PLL_MAIN = 0;
    localparam int PLL_AUDIO = 1;
    localparam int N_PLL = 2;

    typedef enum logic [1:0] {SRC_RC, SRC_EXT, SRC_PLL} scc_src_t;

    typedef struct packed {
        logic [25:0] rsvd;
        logic timer_prescaler_select;
        logic audio_pll_on;
        logic mon_en;
        logic sys_from_pll;
        logic pll_on;
        logic ext_sel;
    } scc_ctrl_t;

    typedef struct packed {
        logic [7:0] rsvd;
        logic [7:0] audio_div;
        logic [7:0] audio_mult;
        logic [7:0] main_mult;
    } scc_pllcfg_t;

    typedef struct packed {
        logic [20:0] rsvd;
        logic [DIV_W-1:0] apb2;
        logic pad2;
        logic [DIV_W-1:0] apb1;
        logic pad1;
        logic [DIV_W-1:0] ahb;
    } scc_presc_t;

    typedef struct packed {
        logic [25:0] rsvd;
        logic switching;
        logic audio_lock;
        logic pll_lock;
        logic ext_ok;
        scc_src_t active;
    } scc_status_t;

    typedef struct packed {
        logic timer_kernel_clock2;
        logic timer_kernel_clock1;
        logic apb2;
        logic apb1;
        logic ahb;
    } scc_ticks_t;

endpackage : scc_pkg

// >>> scc_top.sv
// System clock controller: source switch, PLLs, prescalers, APB regs
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps

// Function
// - Any reset selects the internal RC oscillator as system clock.
// - Software chooses the RC oscillator or the external source.
// - A failed external source makes the switch fall back to RC.
// - A source failure raises the interrupt only when its mask allows.
// - The selected oscillator is the main PLL reference, up to 100 MHz.
// - Loss of the PLL reference raises its own interrupt and unlocks.
// - Prescalers derive AHB, APB2 and APB1 clocks from system clock.
// - An audio PLL and divider make the audio serial master clock.
// - With the select bit set, timer clock is AHB or four times APB.
module scc_top
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CKEN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RC_OSC,
    input wire logic EXT_OSC,
    output logic IRQ,
    output logic SYS_TICK,
    output scc_pkg::scc_ticks_t DOM_TICK,
    output logic AUDIO_MCK
);
    import scc_pkg::*;

    typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_WAIT} scc_sw_t;

    logic [2:0] rc_sync_q;
    logic [2:0] ext_sync_q;
    logic rc_tick;
    logic ext_tick;
    scc_ctrl_t ctrl_q;
    scc_pllcfg_t pllcfg_q;
    scc_presc_t presc_q;
    scc_status_t status;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_stat_d;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] w1c;
    logic irq_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic acc_first;
    logic wr_en;
    logic [31:0] rd_val;
    logic rd_err;
    logic ext_ok;
    logic ext_fail;
    logic ref_ok;
    logic ref_fail;
    logic ref_tick;
    logic [N_PLL-1:0] pll_on;
    logic [N_PLL-1:0] pll_tick;
    logic [N_PLL-1:0] pll_lock;
    logic [7:0] pll_mult [N_PLL];
    logic lock_prev_q;
    scc_sw_t sw_q;
    scc_src_t active_q;
    scc_src_t target_q;
    scc_src_t req_src;
    logic [2:0] src_tick;
    logic [2:0] src_ok;
    logic sys_tick_q;
    logic [N_CH-1:0] ch_in;
    logic [N_CH-1:0] ch_tick;
    logic [DIV_W-1:0] ch_code [N_CH];
    logic [7:0] mck_cnt_q;
    logic mck_q;

    function automatic logic [DIV_W-1:0] tim_code
    (
        input logic [DIV_W-1:0] apb,
        input logic sel
    );
        if (sel)
            return (apb <= TIM_FULL_CODE) ? '0 : apb - TIM_FULL_CODE;
        return (apb == '0) ? '0 : apb - DIV_W'(1);
    endfunction : tim_code

    // Oscillator pins are asynchronous to MCLK
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            rc_sync_q <= '0;
            ext_sync_q <= '0;
        end
        else if (CKEN)
        begin
            rc_sync_q <= {rc_sync_q[1:0], RC_OSC};
            ext_sync_q <= {ext_sync_q[1:0], EXT_OSC};
        end
    end

    assign rc_tick = rc_sync_q[1] & ~rc_sync_q[2];
    assign ext_tick = ext_sync_q[1] & ~ext_sync_q[2];

    scc_mon u_ext_mon
    (
        .clk (MCLK),
        .rst (SRST),
        .ce (CKEN),
        .en (ctrl_q.mon_en && ctrl_q.ext_sel),
        .tick (ext_tick),
        .ok (ext_ok),
        .fail (ext_fail)
    );

    assign ref_tick = ctrl_q.ext_sel ? ext_tick : rc_tick;

    scc_mon u_ref_mon
    (
        .clk (MCLK),
        .rst (SRST),
        .ce (CKEN),
        .en (ctrl_q.mon_en && (ctrl_q.pll_on || ctrl_q.audio_pll_on)),
        .tick (ref_tick),
        .ok (ref_ok),
        .fail (ref_fail)
    );

    assign pll_on = {ctrl_q.audio_pll_on, ctrl_q.pll_on};
    assign pll_mult[PLL_MAIN] = pllcfg_q.main_mult;
    assign pll_mult[PLL_AUDIO] = pllcfg_q.audio_mult;

    // Rate multiplier: each reference tick buys mult output ticks while credit is at most CREDIT_MAX
    for (genvar p = 0; p < N_PLL; p++)
    begin : g_pll
        logic [CREDIT_W-1:0] credit_q;
        logic [CREDIT_W-1:0] add;
        logic [LOCK_W-1:0] lock_cnt_q;
        logic tick_q;
        logic lock_q;

        assign add = (ref_tick && credit_q <= CREDIT_MAX)
            ? CREDIT_W'(pll_mult[p]) : '0;

        always_ff @(posedge MCLK)
        begin
            if (SRST)
            begin
                credit_q <= '0;
                tick_q <= 1'b0;
            end
            else if (CKEN)
            begin
                if (!pll_on[p])
                begin
                    credit_q <= '0;
                    tick_q <= 1'b0;
                end
                else
                begin
                    tick_q <= (credit_q != '0);
                    credit_q <= credit_q + add
                        - CREDIT_W'(credit_q != '0);
                end
            end
        end

        always_ff @(posedge MCLK)
        begin
            if (SRST)
            begin
                lock_cnt_q <= '0;
                lock_q <= 1'b0;
            end
            else if (CKEN)
            begin
                if (!pll_on[p] || ref_fail)
                begin
                    lock_cnt_q <= '0;
                    lock_q <= 1'b0;
                end
                else if (ref_tick && !lock_q)
                begin
                    lock_cnt_q <= lock_cnt_q + LOCK_W'(1);
                    lock_q <= (lock_cnt_q == LOCK_W'(LOCK_REF_TICKS - 1));
                end
            end
        end

        assign pll_tick[p] = tick_q;
        assign pll_lock[p] = lock_q;
    end

    assign src_tick = {pll_tick[PLL_MAIN], ext_tick, rc_tick};
    assign src_ok = {pll_lock[PLL_MAIN] & ref_ok, ext_ok, 1'b1};

    // A failed source drops out of the request at once
    always_comb
    begin
        if (ctrl_q.sys_from_pll && pll_lock[PLL_MAIN] && ref_ok)
            req_src = SRC_PLL;
        else if (ctrl_q.ext_sel && ext_ok)
            req_src = SRC_EXT;
        else
            req_src = SRC_RC;
    end

    // Switch only between ticks of old and new source, never mid-pulse
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            sw_q <= SW_RUN;
            active_q <= SRC_RC;
            target_q <= SRC_RC;
        end
        else if (CKEN)
        begin
            case (sw_q)
                SW_RUN:
                begin
                    if (req_src != active_q)
                    begin
                        target_q <= req_src;
                        // Dead source gives no tick to wait for
                        if (src_ok[active_q])
                            sw_q <= SW_DRAIN;
                        else
                            sw_q <= SW_WAIT;
                    end
                end
                SW_DRAIN:
                begin
                    if (src_tick[active_q] || !src_ok[active_q])
                        sw_q <= SW_WAIT;
                end
                SW_WAIT:
                begin
                    if (req_src != target_q)
                        target_q <= req_src;
                    else if (src_tick[target_q])
                    begin
                        active_q <= target_q;
                        sw_q <= SW_RUN;
                    end
                end
                default:
                    sw_q <= SW_RUN;
            endcase
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
            sys_tick_q <= 1'b0;
        else if (CKEN)
            sys_tick_q <= (sw_q != SW_WAIT) && src_tick[active_q];
    end

    assign ch_in = {{(N_CH - 1){ch_tick[CH_AHB]}}, sys_tick_q};

    always_comb
    begin
        ch_code[CH_AHB] = presc_q.ahb;
        ch_code[CH_APB1] = presc_q.apb1;
        ch_code[CH_APB2] = presc_q.apb2;
        ch_code[CH_TIM1] = tim_code(presc_q.apb1,
            ctrl_q.timer_prescaler_select);
        ch_code[CH_TIM2] = tim_code(presc_q.apb2,
            ctrl_q.timer_prescaler_select);
    end

    for (genvar c = 0; c < N_CH; c++)
    begin : g_div
        scc_div u_div
        (
            .clk (MCLK),
            .rst (SRST),
            .ce (CKEN),
            .tick_in (ch_in[c]),
            .div_code (ch_code[c]),
            .tick_out (ch_tick[c])
        );
    end

    // Audio master clock: toggles every audio_div+1 audio PLL ticks
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            mck_cnt_q <= '0;
            mck_q <= 1'b0;
        end
        else if (CKEN && pll_tick[PLL_AUDIO])
        begin
            if (mck_cnt_q >= pllcfg_q.audio_div)
            begin
                mck_cnt_q <= '0;
                mck_q <= ~mck_q;
            end
            else
                mck_cnt_q <= mck_cnt_q + 8'h01;
        end
    end

    assign acc_first = PSEL && PENABLE && !pready_q;
    assign wr_en = PSEL && PENABLE && pready_q && PWRITE;

    assign status = '{rsvd: '0, switching: (sw_q != SW_RUN),
        audio_lock: pll_lock[PLL_AUDIO], pll_lock: pll_lock[PLL_MAIN],
        ext_ok: ext_ok, active: active_q};

    always_comb
    begin
        rd_err = 1'b0;
        case (PADDR)
            ADDR_CTRL: rd_val = ctrl_q;
            ADDR_PLLCFG: rd_val = pllcfg_q;
            ADDR_PRESC: rd_val = presc_q;
            ADDR_STATUS: rd_val = status;
            ADDR_IRQ_STAT: rd_val = 32'(irq_stat_q);
            ADDR_IRQ_MASK: rd_val = 32'(irq_mask_q);
            default:
            begin
                rd_val = '0;
                rd_err = 1'b1;
            end
        endcase
    end

    // One wait state: answer data is registered for timing
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else if (CKEN)
        begin
            pready_q <= acc_first;
            pslverr_q <= acc_first && rd_err;
            if (acc_first)
                prdata_q <= PWRITE ? '0 : rd_val;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ctrl_q <= scc_ctrl_t'(CTRL_RST);
            pllcfg_q <= scc_pllcfg_t'(PLLCFG_RST);
            presc_q <= scc_presc_t'(PRESC_RST);
            irq_mask_q <= '0;
        end
        else if (CKEN && wr_en)
        begin
            case (PADDR)
                ADDR_CTRL: ctrl_q <= scc_ctrl_t'(PWDATA & CTRL_WMASK);
                ADDR_PLLCFG:
                    pllcfg_q <= scc_pllcfg_t'(PWDATA & PLLCFG_WMASK);
                ADDR_PRESC: presc_q <= scc_presc_t'(PWDATA & PRESC_WMASK);
                ADDR_IRQ_MASK: irq_mask_q <= PWDATA[IRQ_W-1:0];
                default:
                    irq_mask_q <= irq_mask_q;
            endcase
        end
    end

    assign irq_ev[IRQ_EXT_FAIL] = ext_fail;
    assign irq_ev[IRQ_PLL_FAIL] = ref_fail;
    assign irq_ev[IRQ_PLL_LOCK] = pll_lock[PLL_MAIN] && !lock_prev_q;
    assign w1c = (wr_en && PADDR == ADDR_IRQ_STAT)
        ? PWDATA[IRQ_W-1:0] : '0;
    // An event in the clearing cycle survives the clear
    assign irq_stat_d = (irq_stat_q & ~w1c) | irq_ev;

    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            irq_stat_q <= '0;
            lock_prev_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (CKEN)
        begin
            irq_stat_q <= irq_stat_d;
            lock_prev_q <= pll_lock[PLL_MAIN];
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign IRQ = irq_q;
    assign SYS_TICK = sys_tick_q;
    assign DOM_TICK = scc_ticks_t'(ch_tick);
    assign AUDIO_MCK = mck_q;

endmodule : scc_top
